// file: logic/aksp_defs.svh
`ifndef AKSP_DEFS_SVH
`define AKSP_DEFS_SVH

// ==========================================================================
// buffering
`define AKSP_FIFO_DEPTH 32
`define AKSP_LEVEL_W 6

// ==========================================================================
// stream word
`define AKSP_DEFAULT_DATA_W 64

// ==========================================================================
// register bus
`define AKSP_ADR_W 8
`define AKSP_REG_CTRL 8'h00
`define AKSP_REG_STATUS 8'h04
`define AKSP_REG_IN_WORDS 8'h08
`define AKSP_REG_IN_XFERS 8'h0C
`define AKSP_REG_OUT_XFERS 8'h10
`define AKSP_REG_INFO 8'h14

// ==========================================================================
// control fields
`define AKSP_CTRL_SPLIT_RESET 16'h0000
`define AKSP_CTRL_CLEAR_BIT 31

// ==========================================================================
// status and info fields
`define AKSP_ST_IN_XFER_BIT 8
`define AKSP_ST_OUT_VALID_BIT 9
`define AKSP_ST_OUT_STALL_BIT 10
`define AKSP_ST_OUT_XFER_BIT 11
`define AKSP_INFO_WIDTH_OK_BIT 16

`endif

// file: logic/aksp_pkg.sv
`include "aksp_defs.svh"

package aksp_pkg;

   // ==========================================================================
   // types
   typedef logic [31:0] aksp_word_t;
   typedef logic [`AKSP_ADR_W-1:0] aksp_adr_t;
   typedef logic [`AKSP_LEVEL_W-1:0] aksp_level_t;

   // position of a port within a transfer
   typedef enum logic [0:0] {
      AKSP_IDLE,
      AKSP_IN_XFER
   } aksp_phase_e;

endpackage

// file: logic/aksp_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "aksp_defs.svh"

interface aksp_fifo_if #(
   parameter int W = 8
);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   logic [`AKSP_LEVEL_W-1:0] level;

   modport user (
      output push_valid,
      output push_data,
      output pop_ready,
      input push_ready,
      input pop_valid,
      input pop_data,
      input level
   );

   modport store (
      input push_valid,
      input push_data,
      input pop_ready,
      output push_ready,
      output pop_valid,
      output pop_data,
      output level
   );
endinterface

`default_nettype wire

// file: logic/aksp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "aksp_defs.svh"

module aksp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `AKSP_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // both sides of the buffer
   aksp_fifo_if.store f
);
   import aksp_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } aksp_fifo_st_s;

   aksp_fifo_st_s s;
   aksp_fifo_st_s next_s;
   logic push;
   logic pop;

   // ==========================================================================
   // handshakes
   assign f.push_ready = (s.count != (AW+1)'(DEPTH));
   assign f.pop_valid = (s.count != '0);
   assign f.pop_data = s.mem[s.rptr];
   assign f.level = `AKSP_LEVEL_W'(s.count);
   assign push = f.push_valid & f.push_ready;
   assign pop = f.pop_valid & f.pop_ready;

   // ==========================================================================
   // state
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wptr] = f.push_data;
         next_s.wptr = s.wptr + 1'b1;
      end
      if (pop) begin
         next_s.rptr = s.rptr + 1'b1;
      end
      case ({push, pop})
         2'b10: next_s.count = s.count + 1'b1;
         2'b01: next_s.count = s.count - 1'b1;
         default: next_s.count = s.count;
      endcase
      if (rst_i) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end
endmodule

`default_nettype wire

// file: logic/aksp_keep_fix.sv
`timescale 1ns/10ps
`default_nettype none

module aksp_keep_fix #(
   parameter int KW = 8
) (
   // word sideband
   input wire logic [KW-1:0] keep_i,
   input wire logic last_i,
   // cleaned mask
   output logic [KW-1:0] keep_o
);
   import aksp_pkg::*;

   localparam int CW = $clog2(KW) + 1;

   function automatic logic [CW-1:0] ones(input logic [KW-1:0] k);
      logic [CW-1:0] n;
      n = '0;
      for (int i = 0; i < KW; i++) begin
         n = n + CW'(k[i]);
      end
      return n;
   endfunction

   logic [CW-1:0] nbytes;
   logic [CW-1:0] used;

   // an empty final word is sent as a full one
   assign nbytes = ones(keep_i);
   assign used = (nbytes == '0) ? CW'(KW) : nbytes;

   // ==========================================================================
   // contiguous low-order bytes on the final word, all ones elsewhere
   for (genvar i = 0; i < KW; i++) begin : g_byte
      assign keep_o[i] = last_i ? (CW'(i) < used) : 1'b1;
   end
endmodule

`default_nettype wire

// file: logic/aksp_stream_port.sv
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "aksp_defs.svh"

module aksp_stream_port #(
   parameter int DATA_W = `AKSP_DEFAULT_DATA_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire aksp_pkg::aksp_adr_t wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire aksp_pkg::aksp_word_t wb_dat_i,
   output aksp_pkg::aksp_word_t wb_dat_o,
   output logic wb_ack_o,
   // incoming stream
   input wire logic [DATA_W-1:0] s_axis_tdata_i,
   input wire logic [DATA_W/8-1:0] s_axis_tkeep_i,
   input wire logic s_axis_tlast_i,
   input wire logic s_axis_tvalid_i,
   output logic s_axis_tready_o,
   // outgoing stream
   output logic [DATA_W-1:0] m_axis_tdata_o,
   output logic [DATA_W/8-1:0] m_axis_tkeep_o,
   output logic m_axis_tlast_o,
   output logic m_axis_tvalid_o,
   input wire logic m_axis_tready_i
);
   import aksp_pkg::*;

   // ==========================================================================
   // word layout
   localparam int KEEP_W = DATA_W / 8;
   localparam int WORD_W = DATA_W + KEEP_W + 1;

   function automatic logic width_ok(input int w);
      return (w == 8) || (w == 16) || (w == 32) || (w == 64) ||
             (w == 128) || (w == 256) || (w == 512);
   endfunction

   function automatic logic hit(input aksp_adr_t a, input aksp_adr_t off);
      return a == off;
   endfunction

   localparam logic WIDTH_OK = width_ok(DATA_W);

   // ==========================================================================
   // state
   typedef struct packed {
      logic [DATA_W-1:0] out_data;
      logic [KEEP_W-1:0] out_keep;
      logic out_last;
      logic out_valid;
      aksp_phase_e in_phase;
      aksp_phase_e out_phase;
      logic [15:0] split_len;
      logic [15:0] out_pos;
      logic [31:0] in_words;
      logic [31:0] in_xfers;
      logic [31:0] out_xfers;
      logic ack;
      logic [31:0] rdata;
   } aksp_top_st_s;

   aksp_top_st_s s;
   aksp_top_st_s next_s;

   // ==========================================================================
   // buffer between the two stream sides
   aksp_fifo_if #(.W(WORD_W)) fq ();

   aksp_fifo #(
      .W(WORD_W),
      .DEPTH(`AKSP_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .f(fq.store)
   );

   logic in_take;
   logic out_load;
   logic out_take;
   logic pop_last;
   logic [KEEP_W-1:0] pop_keep;
   logic [DATA_W-1:0] pop_data;
   logic cut;
   logic word_last;
   logic [KEEP_W-1:0] fix_keep;

   // only data, keep and last cross; no user, id or dest field exists
   assign fq.push_data = {s_axis_tlast_i, s_axis_tkeep_i, s_axis_tdata_i};
   assign fq.push_valid = s_axis_tvalid_i;
   assign s_axis_tready_o = fq.push_ready;
   assign in_take = s_axis_tvalid_i & fq.push_ready;

   assign pop_last = fq.pop_data[WORD_W-1];
   assign pop_keep = fq.pop_data[WORD_W-2:DATA_W];
   assign pop_data = fq.pop_data[DATA_W-1:0];

   // output register reloads when empty or when its word is taken
   assign out_load = ~s.out_valid | m_axis_tready_i;
   assign fq.pop_ready = out_load;
   assign out_take = fq.pop_valid & out_load;

   // optional split of long transfers into pieces of split_len words
   assign cut = (s.split_len != 16'h0000) && (s.out_pos == s.split_len - 16'h0001);
   assign word_last = pop_last | cut;

   aksp_keep_fix #(
      .KW(KEEP_W)
   ) u_keep (
      .keep_i(pop_keep),
      .last_i(word_last),
      .keep_o(fix_keep)
   );

   // ==========================================================================
   // register read view
   aksp_word_t status;
   aksp_word_t info;
   aksp_word_t rd_mux;

   always_comb begin
      status = '0;
      status[`AKSP_LEVEL_W-1:0] = fq.level;
      status[`AKSP_ST_IN_XFER_BIT] = (s.in_phase == AKSP_IN_XFER);
      status[`AKSP_ST_OUT_VALID_BIT] = s.out_valid;
      status[`AKSP_ST_OUT_STALL_BIT] = s.out_valid & ~m_axis_tready_i;
      status[`AKSP_ST_OUT_XFER_BIT] = (s.out_phase == AKSP_IN_XFER);
      info = '0;
      info[9:0] = 10'(DATA_W);
      info[`AKSP_INFO_WIDTH_OK_BIT] = WIDTH_OK;
      if (hit(wb_adr_i, `AKSP_REG_CTRL)) begin
         rd_mux = {16'h0000, s.split_len};
      end else if (hit(wb_adr_i, `AKSP_REG_STATUS)) begin
         rd_mux = status;
      end else if (hit(wb_adr_i, `AKSP_REG_IN_WORDS)) begin
         rd_mux = s.in_words;
      end else if (hit(wb_adr_i, `AKSP_REG_IN_XFERS)) begin
         rd_mux = s.in_xfers;
      end else if (hit(wb_adr_i, `AKSP_REG_OUT_XFERS)) begin
         rd_mux = s.out_xfers;
      end else if (hit(wb_adr_i, `AKSP_REG_INFO)) begin
         rd_mux = info;
      end else begin
         rd_mux = '0;
      end
   end

   // ==========================================================================
   // next state
   always_comb begin
      next_s = s;

      // bus slave: one wait state, ack for one cycle
      next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
      if (wb_cyc_i & wb_stb_i & ~s.ack) begin
         next_s.rdata = wb_we_i ? 32'h0000_0000 : rd_mux;
         if (wb_we_i && hit(wb_adr_i, `AKSP_REG_CTRL)) begin
            if (wb_sel_i[0]) begin
               next_s.split_len[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               next_s.split_len[15:8] = wb_dat_i[15:8];
            end
            // counter clear comes first so a same-cycle event still counts
            if (wb_sel_i[3] && wb_dat_i[`AKSP_CTRL_CLEAR_BIT]) begin
               next_s.in_words = '0;
               next_s.in_xfers = '0;
               next_s.out_xfers = '0;
            end
         end
      end

      // incoming side: track transfers closed by last
      if (in_take) begin
         next_s.in_words = next_s.in_words + 32'h0000_0001;
      end
      case (s.in_phase)
         AKSP_IDLE: begin
            if (in_take && !s_axis_tlast_i) begin
               next_s.in_phase = AKSP_IN_XFER;
            end
            if (in_take && s_axis_tlast_i) begin
               next_s.in_xfers = next_s.in_xfers + 32'h0000_0001;
            end
         end
         AKSP_IN_XFER: begin
            if (in_take && s_axis_tlast_i) begin
               next_s.in_phase = AKSP_IDLE;
               next_s.in_xfers = next_s.in_xfers + 32'h0000_0001;
            end
         end
         default: begin
            next_s.in_phase = AKSP_IDLE;
         end
      endcase

      // outgoing side: hold the word until the sink takes it
      if (out_take) begin
         next_s.out_data = pop_data;
         next_s.out_keep = fix_keep;
         next_s.out_last = word_last;
         next_s.out_valid = 1'b1;
         next_s.out_pos = word_last ? 16'h0000 : s.out_pos + 16'h0001;
      end else if (m_axis_tready_i) begin
         next_s.out_valid = 1'b0;
      end
      case (s.out_phase)
         AKSP_IDLE: begin
            if (out_take && !word_last) begin
               next_s.out_phase = AKSP_IN_XFER;
            end
            if (out_take && word_last) begin
               next_s.out_xfers = next_s.out_xfers + 32'h0000_0001;
            end
         end
         AKSP_IN_XFER: begin
            if (out_take && word_last) begin
               next_s.out_phase = AKSP_IDLE;
               next_s.out_xfers = next_s.out_xfers + 32'h0000_0001;
            end
         end
         default: begin
            next_s.out_phase = AKSP_IDLE;
         end
      endcase

      // runs straight out of reset, no start or stop exists
      if (rst_i) begin
         next_s = '0;
         next_s.split_len = `AKSP_CTRL_SPLIT_RESET;
      end
   end

   // state holds by itself whenever no word moves, no bus cycle runs and reset is low
   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // ==========================================================================
   // outputs; data reaches the far side only through the streams
   assign m_axis_tdata_o = s.out_data;
   assign m_axis_tkeep_o = s.out_keep;
   assign m_axis_tlast_o = s.out_last;
   assign m_axis_tvalid_o = s.out_valid;
   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
endmodule

`default_nettype wire

// file: sim/aksp_stream_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// port checker
module aksp_stream_port_assertions #(
   parameter int DATA_W = 64
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // streams
   input wire logic s_axis_tvalid_i,
   input wire logic s_axis_tready_o,
   input wire logic [DATA_W-1:0] m_axis_tdata_o,
   input wire logic [DATA_W/8-1:0] m_axis_tkeep_o,
   input wire logic m_axis_tlast_o,
   input wire logic m_axis_tvalid_o,
   input wire logic m_axis_tready_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence in_take;
      s_axis_tvalid_i && s_axis_tready_o;
   endsequence
   sequence out_empty;
      !m_axis_tvalid_o;
   endsequence
   chk_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_out_hold: assert property (
      m_axis_tvalid_o && !m_axis_tready_i |=> m_axis_tvalid_o && $stable(m_axis_tdata_o)
      && $stable(m_axis_tkeep_o) && $stable(m_axis_tlast_o))
      else $error("stalled word changed");
   chk_keep_full: assert property (
      m_axis_tvalid_o && !m_axis_tlast_o |-> m_axis_tkeep_o == '1)
      else $error("partial keep on non-final word");
   chk_keep_contig: assert property (
      m_axis_tvalid_o && m_axis_tlast_o |-> m_axis_tkeep_o != '0
      && ((m_axis_tkeep_o + 1'b1) & m_axis_tkeep_o) == '0)
      else $error("final keep not low contiguous");
   chk_first_word: assert property (
      in_take ##0 out_empty |-> ##[1:2] m_axis_tvalid_o)
      else $error("taken word not forwarded");
   chk_ready_run: assert property ($fell(rst_i) |-> s_axis_tready_o)
      else $error("not ready after reset");
   chk_valid_reset: assert property (disable iff (1'b0) rst_i |=> !m_axis_tvalid_o)
      else $error("valid during reset");
endmodule
bind aksp_stream_port aksp_stream_port_assertions #(.DATA_W(DATA_W)) aksp_stream_port_assertions_inst (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .s_axis_tvalid_i(s_axis_tvalid_i),
   .s_axis_tready_o(s_axis_tready_o),
   .m_axis_tdata_o(m_axis_tdata_o),
   .m_axis_tkeep_o(m_axis_tkeep_o),
   .m_axis_tlast_o(m_axis_tlast_o),
   .m_axis_tvalid_o(m_axis_tvalid_o),
   .m_axis_tready_i(m_axis_tready_i)
);
`default_nettype wire

// file: sim/aksp_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// downstream sink pacing
module aksp_sink_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pacing
   input wire logic stall_i,
   input wire logic slow_i,
   // handshake
   output logic tready_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tready_o <= 1'b0;
      end else begin
         tready_o <= stall_i ? 1'b0 : (slow_i ? ~tready_o : 1'b1);
      end
   end
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "aksp_defs.svh"
module testbench;
   import aksp_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
   logic [3:0] wb_sel = 0;
   aksp_adr_t wb_adr = 0;
   aksp_word_t wb_wdat = 0, wb_rdat, q;
   logic [31:0] s_data = 0, m_data, k;
   logic [3:0] s_keep = 0, m_keep;
   logic s_last = 0, s_valid = 0, s_ready, m_last, m_valid, m_ready, stall = 0, slow = 0, r;
   logic [3:0] kt[6] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h5, 4'h0};
   int errors = 0, n_checks = 0, cycles = 0;
   logic [36:0] exp_q[$];
   always #4 clk_i = ~clk_i;
   aksp_stream_port #(.DATA_W(32)) aksp_stream_port_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .s_axis_tdata_i(s_data), .s_axis_tkeep_i(s_keep), .s_axis_tlast_i(s_last),
      .s_axis_tvalid_i(s_valid), .s_axis_tready_o(s_ready), .m_axis_tdata_o(m_data),
      .m_axis_tkeep_o(m_keep), .m_axis_tlast_o(m_last), .m_axis_tvalid_o(m_valid),
      .m_axis_tready_i(m_ready));
   aksp_sink_model aksp_sink_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
      .slow_i(slow), .tready_o(m_ready)); // link bound here, never set over the bus
   // =====
   // helpers
   function automatic logic [3:0] keep_exp(input logic [3:0] kp, input logic l);
      int n;
      n = $countones(kp);
      if (!l || n == 0) return 4'hF;
      return 4'((5'h01 << n) - 5'h01);
   endfunction
   task automatic check(input logic [36:0] seen, input logic [36:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wb(input logic we, input aksp_adr_t a, input aksp_word_t d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hF;
      // ack and read data are both taken at the rising edge that shows ack high
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic send(input logic [31:0] d, input logic [3:0] kp, input logic l);
      logic rd;
      s_data <= d;
      s_keep <= kp;
      s_last <= l;
      s_valid <= 1'b1;
      exp_q.push_back({l, keep_exp(kp, l), d});
      do begin
         @(negedge clk_i);
         rd = s_ready;
         @(posedge clk_i);
      end while (rd !== 1'b1);
   endtask
   task automatic drain;
      s_valid <= 1'b0;
      repeat (300) if (exp_q.size() != 0) @(posedge clk_i);
      @(posedge clk_i);
      check(exp_q.size(), 0);
   endtask
   // =====
   // output monitor and timeout
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
      if (!rst_i && m_valid && m_ready) begin
         if (exp_q.size() == 0) check(37'h0, 37'h1);
         else check({m_last, m_keep, m_data}, exp_q.pop_front());
      end
   end
   // =====
   // scenarios
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, `AKSP_REG_INFO, 0);
      check(q[16:0], {1'b1, 16'd32});
      wb(0, `AKSP_REG_STATUS, 0);
      check(q[11:0], 12'h000);
      wb(1, `AKSP_REG_STATUS, 32'hFFFF_FFFF);
      wb(0, `AKSP_REG_STATUS, 0);
      check(q[11:0], 12'h000);
      wb(0, 8'h40, 0);
      check(q, 32'h0);
      slow <= 1'b1;
      foreach (kt[i]) begin
         send(32'h10 + i, 4'h2, 1'b0);
         send(32'hA0 + i, kt[i], 1'b1);
      end
      drain();
      wb(0, `AKSP_REG_IN_WORDS, 0);
      check(q, 32'd12);
      wb(0, `AKSP_REG_IN_XFERS, 0);
      check(q, 32'd6);
      wb(0, `AKSP_REG_OUT_XFERS, 0);
      check(q, 32'd6);
      wb(1, `AKSP_REG_CTRL, 32'h8000_0000);
      wb(0, `AKSP_REG_IN_WORDS, 0);
      check(q, 32'd0);
      // cut transfers every three words
      wb(1, `AKSP_REG_CTRL, 32'h0000_0003);
      wb(0, `AKSP_REG_CTRL, 0);
      check(q, 32'h0000_0003);
      for (int i = 0; i < 5; i++) begin
         send(32'h200 + i, 4'hF, i == 4);
         if (i == 2) exp_q[exp_q.size() - 1][36] = 1'b1;
      end
      drain();
      wb(0, `AKSP_REG_OUT_XFERS, 0);
      check(q, 32'd2);
      wb(1, `AKSP_REG_CTRL, 32'h0000_0000);
      // fill the buffer with the sink stalled
      slow <= 1'b0;
      stall <= 1'b1;
      k = 0;
      repeat (40) begin
         s_data <= 32'h100 + k;
         s_keep <= 4'hF;
         s_last <= (k[2:0] == 3'h7);
         s_valid <= 1'b1;
         @(negedge clk_i);
         r = s_ready;
         @(posedge clk_i);
         if (r) begin
            exp_q.push_back({k[2:0] == 3'h7, 4'hF, 32'h100 + k});
            k++;
         end
      end
      @(negedge clk_i);
      check(s_ready, 1'b0);
      @(posedge clk_i);
      wb(0, `AKSP_REG_STATUS, 0);
      check({q[10:9], q[5:0]}, 8'hE0);
      stall <= 1'b0;
      drain();
      wb(0, `AKSP_REG_STATUS, 0);
      check({q[11:8], q[5:0]}, 10'h240);
      report_and_stop();
   end
endmodule
`default_nettype wire
